// ==== verilog/pwm_ctl_pkg.sv ====
package pwm_ctl_pkg;
  // ------------------------------------------------------------
  // Register indexes, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_MODE      = 8'h1A;
  localparam logic [7:0] IDX_SYNC      = 8'h1B;
  localparam logic [7:0] IDX_PRESET    = 8'h1C;
  localparam logic [7:0] IDX_MASK_BUF  = 8'h1D;
  localparam logic [7:0] IDX_PROTECT   = 8'h20;
  localparam int         IDX_LSB       = 2;
  localparam int         IDX_MSB       = 9;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_MODE      = 8'h04;
  localparam logic [7:0] RST_SYNC      = 8'h00;
  localparam logic [7:0] RST_PRESET    = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'h00;
  // ------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------
  localparam int MODE_IRQ_EN   = 7;
  localparam int MODE_FLT_HI   = 6;
  localparam int MODE_FLT_LO   = 5;
  localparam int MODE_SELFTEST = 4;
  localparam int MODE_ROUTE    = 3;
  localparam int MODE_UNLOCK   = 2;
  localparam int MODE_PRESET   = 1;
  localparam int MODE_EXT_EN   = 0;
  // ------------------------------------------------------------
  // Sync register fields and protect register field
  // ------------------------------------------------------------
  localparam int SYNC_SW       = 7;
  localparam int SYNC_EXT_HI   = 6;
  localparam int SYNC_EXT_LO   = 4;
  localparam int SYNC_MASK_SEL = 3;
  localparam int SYNC_RELOAD   = 2;
  localparam int SYNC_UPPER    = 1;
  localparam int SYNC_LOWER    = 0;
  localparam int PROT_LOCK     = 0;

  typedef enum logic [1:0] {
    FLT_OFF       = 2'b00,
    FLT_EVEN_MAN  = 2'b01,
    FLT_ALL_MAN   = 2'b10,
    FLT_ALL_AUTO  = 2'b11
  } fault_mode_t;
endpackage : pwm_ctl_pkg

// ==== verilog/ctl_ifs.sv ====
`timescale 1ns/10ps
interface reg_access_if;
  logic       wr;
  logic [7:0] widx;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] ridx;
  logic [7:0] rdata;
  modport port (output wr, widx, wdata, rd, ridx, input rdata);
  modport regs (input wr, widx, wdata, rd, ridx, output rdata);
endinterface : reg_access_if

interface trig_pulse_if #(parameter int N = 3);
  logic [N-1:0] pulse;
  modport src (output pulse);
  modport dst (input pulse);
endinterface : trig_pulse_if

// ==== verilog/trig_edge_detect.sv ====
`timescale 1ns/10ps
module trig_edge_detect #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [N-1:0] trig_in,
  trig_pulse_if.src         tp
);
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  logic [N-1:0] level;
  logic [N-1:0] pulse;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= trig_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= '0;
      pulse <= '0;
    end else if (ce) begin
      level <= ((s2 ~^ s3) & s3) | (~(s2 ~^ s3) & level);
      pulse <= (s2 ~^ s3) & s3 & ~level;
    end
  end

  assign tp.pulse = pulse;

  a_edge_once: assert property (@(posedge clk) disable iff (srst)
    ce && |pulse |=> (pulse & $past(pulse)) == '0 || !ce)
    else $error("trigger pulse lasted two cycles");
endmodule : trig_edge_detect

// ==== verilog/ahb_reg_port.sv ====
`timescale 1ns/10ps
module ahb_reg_port
  import pwm_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  reg_access_if.port       bus
);
  logic       take;
  logic       word_ok;
  logic       dph_active;
  logic       dph_wr;
  logic [7:0] dph_idx;

  assign take    = hsel && htrans[1] && hready && ce;
  assign word_ok = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0) && (haddr[31:10] == '0);

  // ------------------------------------------------------------
  // Address phase capture
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dph_active <= 1'b0;
      dph_wr     <= 1'b0;
      dph_idx    <= 8'h00;
    end else if (ce) begin
      dph_active <= take;
      dph_wr     <= take && hwrite && word_ok;
      dph_idx    <= haddr[IDX_MSB:IDX_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= '0;
    end else if (bus.rd) begin
      hrdata <= {24'h000000, bus.rdata};
    end
  end

  assign bus.rd    = take && !hwrite && word_ok;
  assign bus.ridx  = haddr[IDX_MSB:IDX_LSB];
  assign bus.wr    = dph_wr && ce;
  assign bus.widx  = dph_idx;
  assign bus.wdata = hwdata[7:0];
  // Clock enable low stretches a pending data phase
  assign hreadyout = ce || !dph_active;
  assign hresp     = HRESP_OKAY;
endmodule : ahb_reg_port

// ==== verilog/pwm_mode_sync_control.sv ====
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module pwm_mode_sync_control
  import pwm_ctl_pkg::*;
#(
  parameter int N_EXT = 3,
  parameter int N_CH  = 8
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            ce,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic [1:0]           hresp,
  output logic [31:0]          hrdata,
  input  wire logic [N_EXT-1:0] ext_trig_in,
  input  wire logic            fault_flag,
  input  wire logic            cnt_at_limit,
  input  wire logic            cnt_at_start,
  output logic                 fault_irq,
  output logic                 fault_ctrl_on,
  output logic                 fault_even_only,
  output logic                 fault_auto_clear,
  output logic                 capture_selftest_enable,
  output logic                 extended_feature_enable,
  output logic                 write_protect_off,
  output logic                 preset_strobe,
  output logic [N_CH-1:0]      channel_preset_level,
  output logic [N_CH-1:0]      output_mask_register,
  output logic                 limit_value_load,
  output logic                 start_value_load,
  output logic                 counter_reload,
  output logic                 sync_event
);
  // ------------------------------------------------------------
  // Bus front end and trigger inputs
  // ------------------------------------------------------------
  reg_access_if        rb ();
  trig_pulse_if #(.N(N_EXT)) tp ();

  ahb_reg_port u_port (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .bus       (rb.port)
  );

  trig_edge_detect #(.N(N_EXT)) u_edge (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .trig_in (ext_trig_in),
    .tp      (tp.src)
  );

  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = rb.wr && (rb.widx == idx);
  endfunction : wr_to

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic              fault_irq_enable;
  fault_mode_t       fault_handling_select;
  logic              sync_trigger_routing_select;
  logic              protect_unlock;
  logic              lock_armed;
  logic [7:0]        sync_cfg;
  logic [N_CH-1:0]   output_preset_register;
  logic [N_CH-1:0]   mask_buffer;
  logic              limit_pending;
  logic              software_sync_trigger;
  logic [N_EXT-1:0]  ext_select;
  logic              output_mask_sync_select;
  logic              counter_reload_on_sync;
  logic              upper_boundary_update;
  logic              lower_boundary_update;

  assign software_sync_trigger   = sync_cfg[SYNC_SW];
  assign ext_select              = sync_cfg[SYNC_EXT_HI:SYNC_EXT_LO];
  assign output_mask_sync_select = sync_cfg[SYNC_MASK_SEL];
  assign counter_reload_on_sync  = sync_cfg[SYNC_RELOAD];
  assign upper_boundary_update   = sync_cfg[SYNC_UPPER];
  assign lower_boundary_update   = sync_cfg[SYNC_LOWER];

  // ------------------------------------------------------------
  // Mode register, open and protected fields
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_irq_enable            <= RST_MODE[MODE_IRQ_EN];
      sync_trigger_routing_select <= RST_MODE[MODE_ROUTE];
    end else if (ce && wr_to(IDX_MODE)) begin
      fault_irq_enable            <= rb.wdata[MODE_IRQ_EN];
      sync_trigger_routing_select <= rb.wdata[MODE_ROUTE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_handling_select   <= fault_mode_t'(RST_MODE[MODE_FLT_HI:MODE_FLT_LO]);
      capture_selftest_enable <= RST_MODE[MODE_SELFTEST];
      extended_feature_enable <= RST_MODE[MODE_EXT_EN];
    end else if (ce && wr_to(IDX_MODE) && protect_unlock) begin
      fault_handling_select   <= fault_mode_t'(rb.wdata[MODE_FLT_HI:MODE_FLT_LO]);
      capture_selftest_enable <= rb.wdata[MODE_SELFTEST];
      extended_feature_enable <= rb.wdata[MODE_EXT_EN];
    end
  end

  // ------------------------------------------------------------
  // Write protection unlock sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_armed <= 1'b0;
    end else if (ce) begin
      if (rb.rd && rb.ridx == IDX_PROTECT && !protect_unlock) begin
        lock_armed <= 1'b1;
      end else if (wr_to(IDX_MODE) || wr_to(IDX_PROTECT)) begin
        lock_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      protect_unlock <= RST_MODE[MODE_UNLOCK];
    end else if (ce) begin
      if (wr_to(IDX_PROTECT) && rb.wdata[PROT_LOCK]) begin
        protect_unlock <= 1'b0;
      end else if (wr_to(IDX_MODE) && rb.wdata[MODE_UNLOCK] && lock_armed) begin
        protect_unlock <= 1'b1;
      end
    end
  end

  assign write_protect_off = protect_unlock;

  // ------------------------------------------------------------
  // Fault mode decode and interrupt request
  // ------------------------------------------------------------
  always_comb begin
    fault_ctrl_on    = 1'b0;
    fault_even_only  = 1'b0;
    fault_auto_clear = 1'b0;
    case (fault_handling_select)
      FLT_OFF:      fault_ctrl_on = 1'b0;
      FLT_EVEN_MAN: begin
        fault_ctrl_on   = 1'b1;
        fault_even_only = 1'b1;
      end
      FLT_ALL_MAN:  fault_ctrl_on = 1'b1;
      FLT_ALL_AUTO: begin
        fault_ctrl_on    = 1'b1;
        fault_auto_clear = 1'b1;
      end
      default:      fault_ctrl_on = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_irq <= 1'b0;
    end else if (ce) begin
      fault_irq <= fault_irq_enable && fault_ctrl_on && fault_flag;
    end
  end

  // ------------------------------------------------------------
  // Sync configuration, preset levels and mask buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_cfg <= RST_SYNC;
    end else if (ce && wr_to(IDX_SYNC)) begin
      sync_cfg <= rb.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      output_preset_register <= RST_PRESET[N_CH-1:0];
    end else if (ce && wr_to(IDX_PRESET)) begin
      output_preset_register <= rb.wdata[N_CH-1:0];
    end
  end

  assign channel_preset_level = output_preset_register;

  always_ff @(posedge clk) begin
    if (srst) begin
      preset_strobe <= 1'b0;
    end else if (ce) begin
      preset_strobe <= wr_to(IDX_MODE) && rb.wdata[MODE_PRESET];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_buffer <= RST_MASK[N_CH-1:0];
    end else if (ce && wr_to(IDX_MASK_BUF)) begin
      mask_buffer <= rb.wdata[N_CH-1:0];
    end
  end

  // ------------------------------------------------------------
  // Trigger routing
  // ------------------------------------------------------------
  logic sw_trig;
  logic hw_trig;
  logic limit_trig;
  logic mask_trig;
  logic boundary_on;
  logic boundary_hit;
  logic limit_fire;

  assign sw_trig = wr_to(IDX_SYNC) && rb.wdata[SYNC_SW];
  assign hw_trig = |(tp.pulse & ext_select);
  assign limit_trig = sw_trig || (hw_trig && !sync_trigger_routing_select);
  assign mask_trig  = hw_trig || (sw_trig && !sync_trigger_routing_select);

  assign boundary_on  = upper_boundary_update || lower_boundary_update;
  assign boundary_hit = (upper_boundary_update && cnt_at_limit) ||
                        (lower_boundary_update && cnt_at_start);
  assign limit_fire   = (limit_pending || limit_trig) && (!boundary_on || boundary_hit);

  // A trigger arriving with the boundary hit is consumed, never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      limit_pending <= 1'b0;
    end else if (ce) begin
      limit_pending <= (limit_pending || limit_trig) && !limit_fire;
    end
  end

  // ------------------------------------------------------------
  // Buffered register loads
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      limit_value_load <= 1'b0;
      start_value_load <= 1'b0;
      sync_event       <= 1'b0;
      counter_reload   <= 1'b0;
    end else if (ce) begin
      limit_value_load <= limit_fire;
      start_value_load <= limit_fire && upper_boundary_update && cnt_at_limit;
      sync_event       <= limit_trig || mask_trig;
      counter_reload   <= mask_trig && counter_reload_on_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      output_mask_register <= RST_MASK[N_CH-1:0];
    end else if (ce && (!output_mask_sync_select || mask_trig)) begin
      output_mask_register <= mask_buffer;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rb.rdata = 8'h00;
    case (rb.ridx)
      IDX_MODE: begin
        rb.rdata = {fault_irq_enable, fault_handling_select, capture_selftest_enable,
                    sync_trigger_routing_select, protect_unlock, 1'b0,
                    extended_feature_enable};
      end
      IDX_SYNC:     rb.rdata = sync_cfg;
      IDX_PRESET:   rb.rdata = output_preset_register;
      IDX_MASK_BUF: rb.rdata = output_mask_register;
      IDX_PROTECT:  rb.rdata = {7'h00, !protect_unlock};
      default:      rb.rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_lock_read;
    ce && rb.rd && rb.ridx == IDX_PROTECT && !protect_unlock;
  endsequence
  sequence s_unlock_write;
    ce && wr_to(IDX_MODE) && rb.wdata[MODE_UNLOCK];
  endsequence

  a_unlock_needs_read: assert property ($rose(protect_unlock) |->
    $past(lock_armed) && $past(wr_to(IDX_MODE) && rb.wdata[MODE_UNLOCK]))
    else $error("unlock set without lock read");
  // Gap is the read data phase plus the write address phase
  a_unlock_sequence: assert property (s_lock_read ##1 (!rb.wr && !rb.rd)[*2]
    ##1 s_unlock_write |=> protect_unlock)
    else $error("unlock sequence did not unlock");
  a_lock_clears: assert property (ce && wr_to(IDX_PROTECT) && rb.wdata[PROT_LOCK]
    |=> !protect_unlock && !write_protect_off)
    else $error("lock write left unlock set");
  a_protect_hold: assert property (ce && wr_to(IDX_MODE) && !protect_unlock
    |=> $stable(fault_handling_select) && $stable(capture_selftest_enable)
        && $stable(extended_feature_enable))
    else $error("protected field changed while locked");
  a_preset_pulse: assert property (ce && wr_to(IDX_MODE) && rb.wdata[MODE_PRESET]
    |=> preset_strobe && channel_preset_level == $past(output_preset_register))
    else $error("preset strobe missing");
  a_preset_reads_zero: assert property (rb.ridx == IDX_MODE |-> !rb.rdata[MODE_PRESET])
    else $error("preset strobe read back as one");
  a_fault_irq_cause: assert property (ce ##1 fault_irq |->
    $past(fault_irq_enable) && $past(fault_handling_select) != FLT_OFF && $past(fault_flag))
    else $error("fault interrupt without cause");
  a_mask_follow: assert property (ce && !output_mask_sync_select
    |=> output_mask_register == $past(mask_buffer))
    else $error("mask did not follow buffer");
  a_counter_reload: assert property (ce && mask_trig && counter_reload_on_sync
    |=> counter_reload ##1 (counter_reload == $past(mask_trig && counter_reload_on_sync)
        || !$past(ce)))
    else $error("counter reload not issued");
  a_boundary_wait: assert property (ce && limit_value_load && $past(boundary_on)
    |-> $past(boundary_hit))
    else $error("buffered load outside boundary");
  a_routing_split: assert property (ce && sync_trigger_routing_select && hw_trig
    && !sw_trig && !limit_pending |=> !limit_value_load)
    else $error("hardware trigger reached limit load");
endmodule : pwm_mode_sync_control

// ==== dv/pwm_mode_sync_control_tb.sv ====
`timescale 1ns/10ps
module pwm_mode_sync_control_tb;
  import pwm_ctl_pkg::*;
  logic        clk = 0, srst = 1, ce = 1, hsel = 1, hwrite = 0, fault_flag = 0;
  logic        cnt_at_limit = 0, cnt_at_start = 0, r;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0]  htrans = 0, hresp, s;
  logic [2:0]  hsize = HSIZE_WORD, ext_trig_in = 0;
  logic        hreadyout, fault_irq, fault_ctrl_on, fault_even_only, fault_auto_clear;
  logic        capture_selftest_enable, extended_feature_enable, write_protect_off;
  logic        preset_strobe, limit_value_load, start_value_load, counter_reload, sync_event;
  logic [7:0]  channel_preset_level, output_mask_register, d, c, om;
  logic [3:0]  e;
  logic [10:0] tc [6] = '{{1'b0, 2'd3, 8'h8C}, {1'b1, 2'd3, 8'h8C}, {1'b0, 2'd0, 8'h1C},
                          {1'b1, 2'd1, 8'h2C}, {1'b0, 2'd2, 8'h4C}, {1'b0, 2'd1, 8'h1C}};
  int          n_errors = 0, checks_done = 0, seed = 90;
  integer      n_sy = 0, n_li = 0, n_st = 0, n_re = 0, b_sy, b_li, b_st, b_re;

  pwm_mode_sync_control pwm_mode_sync_control_i (
    .clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_trig_in(ext_trig_in),
    .fault_flag(fault_flag), .cnt_at_limit(cnt_at_limit), .cnt_at_start(cnt_at_start),
    .fault_irq(fault_irq), .fault_ctrl_on(fault_ctrl_on), .fault_even_only(fault_even_only),
    .fault_auto_clear(fault_auto_clear), .capture_selftest_enable(capture_selftest_enable),
    .extended_feature_enable(extended_feature_enable), .write_protect_off(write_protect_off),
    .preset_strobe(preset_strobe), .channel_preset_level(channel_preset_level),
    .output_mask_register(output_mask_register), .limit_value_load(limit_value_load),
    .start_value_load(start_value_load), .counter_reload(counter_reload),
    .sync_event(sync_event));

  always #20 clk = ~clk;

  // ----------------------------------------
  // Pulse counters
  // ----------------------------------------
  always @(posedge clk) begin
    if (!srst) begin
      n_sy <= n_sy + sync_event;
      n_li <= n_li + limit_value_load;
      n_st <= n_st + start_value_load;
      n_re <= n_re + counter_reload;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rv, {24'h0, exp});
    chk(hresp, HRESP_OKAY);
  endtask : rd

  task automatic snap;
    b_sy = n_sy;
    b_li = n_li;
    b_st = n_st;
    b_re = n_re;
  endtask : snap

  function automatic logic [2:0] fdec(input int m);
    return (m == 0) ? 3'b000 : {1'b1, m == 1, m == 3};
  endfunction : fdec

  function automatic logic [3:0] sexp(input logic rt, input logic [1:0] src,
                                      input logic [7:0] cfg);
    logic sel, sw;
    sw = (src == 2'd3);
    sel = sw ? cfg[7] : cfg[4 + src];
    return {sel, sel & (!rt | sw), sel & (!rt | !sw) & cfg[2], sel & (!rt | !sw)};
  endfunction : sexp

  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    #400000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_MODE, RST_MODE);
    rd(IDX_SYNC, RST_SYNC);
    rd(IDX_PRESET, RST_PRESET);
    rd(IDX_PROTECT, 8'h00);
    rd(8'h3F, 8'h00);
    $display("test reset done");
    fault_flag <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(IDX_MODE, 1'b1, {1'b1, m[1:0], 5'b10001});
      #1 chk({fault_ctrl_on, fault_even_only, fault_auto_clear}, fdec(m));
      chk({capture_selftest_enable, extended_feature_enable}, 2'b11);
      @(posedge clk);
      #1 chk(fault_irq, m != 0);
      @(posedge clk);
      rd(IDX_MODE, {1'b1, m[1:0], 5'b10101});
    end
    bus(IDX_MODE, 1'b1, 8'h51);
    repeat (2) @(posedge clk);
    #1 chk(fault_irq, 1'b0);
    fault_flag <= 1'b0;
    $display("test fault modes done");
    bus(IDX_PROTECT, 1'b1, 8'h01);
    #1 chk(write_protect_off, 1'b0);
    @(posedge clk);
    bus(IDX_MODE, 1'b1, 8'h0C);
    rd(IDX_MODE, 8'h59);
    rd(IDX_PROTECT, 8'h01);
    bus(IDX_MODE, 1'b1, 8'h04);
    #1 chk(write_protect_off, 1'b1);
    @(posedge clk);
    bus(IDX_MODE, 1'b1, 8'h00);
    rd(IDX_MODE, 8'h04);
    $display("test protection done");
    d = $random(seed);
    bus(IDX_PRESET, 1'b1, d);
    #1 chk(channel_preset_level, d);
    @(posedge clk);
    bus(IDX_MODE, 1'b1, 8'h06);
    #1 chk(preset_strobe, 1'b1);
    @(posedge clk);
    #1 chk(preset_strobe, 1'b0);
    @(posedge clk);
    rd(IDX_MODE, 8'h04);
    om = $random(seed);
    bus(IDX_MASK_BUF, 1'b1, om);
    repeat (2) @(posedge clk);
    #1 chk(output_mask_register, om);
    $display("test preset and mask done");
    for (int i = 0; i < 6; i++) begin
      {r, s, c} = tc[i];
      e = sexp(r, s, c);
      bus(IDX_MODE, 1'b1, {4'h0, r, 3'h4});
      bus(IDX_SYNC, 1'b1, c & 8'h7F);
      d = $random(seed);
      bus(IDX_MASK_BUF, 1'b1, d);
      repeat (3) @(posedge clk);
      chk(output_mask_register, om);
      snap();
      if (s == 2'd3) bus(IDX_SYNC, 1'b1, c);
      else begin
        ext_trig_in[s] <= 1'b1;
        repeat (6) @(posedge clk);
        ext_trig_in[s] <= 1'b0;
      end
      repeat (10) @(posedge clk);
      chk(n_sy - b_sy, e[3]);
      chk(n_li - b_li, e[2]);
      chk(n_re - b_re, e[1]);
      if (e[0]) om = d;
      chk(output_mask_register, om);
    end
    $display("test triggers done");
    for (int k = 0; k < 2; k++) begin
      bus(IDX_SYNC, 1'b1, k ? 8'h01 : 8'h02);
      snap();
      bus(IDX_SYNC, 1'b1, k ? 8'h81 : 8'h82);
      repeat (6) @(posedge clk);
      chk(n_li - b_li, 0);
      if (k) cnt_at_start <= 1'b1;
      else cnt_at_limit <= 1'b1;
      @(posedge clk);
      cnt_at_start <= 1'b0;
      cnt_at_limit <= 1'b0;
      repeat (4) @(posedge clk);
      chk(n_li - b_li, 1);
      chk(n_st - b_st, k ? 0 : 1);
    end
    $display("test boundaries done");
    end_sim();
  end
endmodule : pwm_mode_sync_control_tb
